/* File: hw/osld_top.sv */
// Summary of operation
// RQ1 - compatibility mode runs at level three, privileged traps
// RQ2 - real mode runs privileged instructions without fault
// RQ3 - lock prefix checked against io privilege level
// RQ4 - lock legal only on listed memory-destination classes
// RQ5 - memory exchange always locks, prefix or not
// RQ6 - lock held at least over destination operand
// RQ7 - other master may take bus between halves
// RQ8 - protected mode defaults follow code default bit
// RQ9 - real and compatibility modes default sixteen bits
// RQ10 - size prefixes apply in every mode
// RQ11 - gate type sets transfer operand size
// RQ12 - stack big bit picks stack pointer width
// RQ13 - 66h and 67h invert sizes independently
// RQ14 - both prefixes flip both sizes together
// RQ15 - repeated prefix counts as a single one
`include "osld_map.svh"

module osld_top (
  input  wire logic                 mclk,
  input  wire logic                 arst_n,
  // avalon-mm register slave
  input  wire logic [3:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic [31:0]               avs_readdata,
  output logic                      avs_waitrequest,
  // instruction byte stream
  input  wire logic                 ins_valid,
  output logic                      ins_ready,
  input  wire logic [7:0]           ins_byte,
  input  wire osld_pkg::osld_class_t ins_class,
  input  wire logic                 ins_mem_dest,
  input  wire logic                 ins_gate,
  input  wire logic                 ins_gate_32,
  // decode results
  output logic                      dec_valid,
  output logic                      dec_op32,
  output logic                      dec_addr32,
  output logic                      dec_stack32,
  output logic                      dec_lock,
  output logic                      dec_fault_priv,
  output logic                      dec_fault_ud,
  output logic                      dec_fault_lock,
  // memory transfers and bus arbitration
  input  wire logic                 mem_req,
  input  wire logic                 mem_last,
  output logic                      mem_gnt,
  output logic                      bus_lock,
  input  wire logic                 hold_req,
  output logic                      hold_ack
);

  // privileged classes trapped in compatibility mode
  function automatic logic is_priv(input osld_pkg::osld_class_t c);
    case (c)
      osld_pkg::OSLD_CLS_LOAD_INT_TABLE,
      osld_pkg::OSLD_CLS_LOAD_GLOBAL_TBL,
      osld_pkg::OSLD_CLS_LOAD_MACH_STATUS,
      osld_pkg::OSLD_CLS_CTRL_REG_MOVE,
      osld_pkg::OSLD_CLS_CLEAR_TASK_SW,
      osld_pkg::OSLD_CLS_HALT,
      osld_pkg::OSLD_CLS_CACHE_INV,
      osld_pkg::OSLD_CLS_CACHE_WB_INV,
      osld_pkg::OSLD_CLS_TLB_ENTRY_INV: is_priv = 1'b1;
      default:                          is_priv = 1'b0;
    endcase
  endfunction

  // classes that may carry the lock prefix
  function automatic logic lock_ok(input osld_pkg::osld_class_t c);
    case (c)
      osld_pkg::OSLD_CLS_BIT_TEST_SET,
      osld_pkg::OSLD_CLS_BIT_TEST_RESET,
      osld_pkg::OSLD_CLS_BIT_TEST_COMPL,
      osld_pkg::OSLD_CLS_EXCHANGE,
      osld_pkg::OSLD_CLS_EXCHANGE_ADD,
      osld_pkg::OSLD_CLS_COMPARE_EXCHANGE,
      osld_pkg::OSLD_CLS_ALU_ONE,
      osld_pkg::OSLD_CLS_ALU_TWO: lock_ok = 1'b1;
      default:                    lock_ok = 1'b0;
    endcase
  endfunction

  // control register state
  logic [7:0]           ctrl;
  logic [7:0]           next_ctrl;
  osld_pkg::osld_mode_t mode;
  logic                 cs_d;
  logic                 ss_b;
  logic [1:0]           io_privilege_level;
  logic [1:0]           cpl;

  // bus slave state
  logic                 bus_ack;
  logic                 next_bus_ack;
  logic [31:0]          next_readdata;

  // decoder state
  osld_pkg::osld_state_t state;
  osld_pkg::osld_state_t next_state;
  logic                 pfx_op;
  logic                 pfx_addr;
  logic                 pfx_lock;
  logic                 next_pfx_op;
  logic                 next_pfx_addr;
  logic                 next_pfx_lock;
  logic [6:0]           status;
  logic [6:0]           next_status;
  logic [15:0]          faults;
  logic [15:0]          next_faults;

  // decode terms of the current opcode byte
  logic                 opcode_take;
  logic                 is_prefix;
  logic                 default32;
  logic [1:0]           eff_cpl;
  logic                 want_lock;
  logic                 flt_ud;
  logic                 flt_priv;
  logic                 flt_lock;
  logic                 res_op32;
  logic                 res_addr32;
  logic                 res_lock;
  logic                 any_fault;
  logic                 faults_wr;

  // control fields
  assign mode = osld_pkg::osld_mode_t'(
                  ctrl[`OSLD_CTRL_MODE_HI:`OSLD_CTRL_MODE_LO]);
  assign cs_d = ctrl[`OSLD_CTRL_CS_D];
  assign ss_b = ctrl[`OSLD_CTRL_SS_B];
  assign io_privilege_level = ctrl[`OSLD_CTRL_IO_PRIVILEGE_LEVEL_HI:`OSLD_CTRL_IO_PRIVILEGE_LEVEL_LO];
  assign cpl  = ctrl[`OSLD_CTRL_CPL_HI:`OSLD_CTRL_CPL_LO];

  // bus answer one cycle after the request is seen
  always_comb begin
    next_bus_ack  = (avs_read || avs_write) && !bus_ack;
    next_readdata = avs_readdata;
    if (avs_read && !bus_ack) begin
      if (avs_address == `OSLD_ADDR_CTRL) begin
        next_readdata = {24'h000000, ctrl};
      end else if (avs_address == `OSLD_ADDR_STATUS) begin
        next_readdata = {25'h0000000, status};
      end else if (avs_address == `OSLD_ADDR_FAULTS) begin
        next_readdata = {16'h0000, faults};
      end else begin
        next_readdata = 32'h00000000; // unmapped reads zero
      end
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !bus_ack;
  assign faults_wr = avs_write && bus_ack &&
                     (avs_address == `OSLD_ADDR_FAULTS);

  // control register write, low byte lane only
  always_comb begin
    next_ctrl = ctrl;
    if (avs_write && bus_ack && avs_byteenable[0] &&
        (avs_address == `OSLD_ADDR_CTRL)) begin
      next_ctrl = avs_writedata[7:0];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      bus_ack      <= 1'b0;
      avs_readdata <= 32'h00000000;
      ctrl         <= `OSLD_CTRL_RESET;
    end else begin
      bus_ack      <= next_bus_ack;
      avs_readdata <= next_readdata;
      ctrl         <= next_ctrl;
    end
  end

  // prefix recognition and size selection
  assign is_prefix = (ins_byte == `OSLD_PFX_OPSIZE) ||
                     (ins_byte == `OSLD_PFX_ADSIZE) ||
                     (ins_byte == `OSLD_PFX_LOCK);
  assign ins_ready   = (state == osld_pkg::OSLD_ST_SCAN);
  assign opcode_take = ins_valid && ins_ready && !is_prefix;

  // descriptor default applies only in protected mode
  assign default32 = (mode == osld_pkg::OSLD_MODE_PROT) &&
                     cs_d; // see RQ8 see RQ9

  // prefixes invert each default on their own, in every mode
  assign res_op32 = ins_gate ? ins_gate_32 // see RQ11
                             : (default32 ^ pfx_op); // see RQ10 see RQ13
  assign res_addr32 = default32 ^ pfx_addr; // see RQ13 see RQ14

  // compatibility mode always runs at level three
  assign eff_cpl = (mode == osld_pkg::OSLD_MODE_COMPAT) ?
                   `OSLD_COMPAT_CPL : cpl; // see RQ1

  // memory exchange locks itself
  assign want_lock = pfx_lock ||
                     ((ins_class == osld_pkg::OSLD_CLS_EXCHANGE) &&
                      ins_mem_dest); // see RQ5

  // lock legal only on listed classes with memory destination
  assign flt_ud = pfx_lock &&
                  !(lock_ok(ins_class) && ins_mem_dest); // see RQ4

  // privileged trap only in compatibility mode, not in real mode
  assign flt_priv = !flt_ud &&
                    (mode == osld_pkg::OSLD_MODE_COMPAT) &&
                    is_priv(ins_class); // see RQ1 see RQ2

  // lock prefix outside real mode needs io privilege
  assign flt_lock = !flt_ud && !flt_priv && pfx_lock &&
                    (mode != osld_pkg::OSLD_MODE_REAL) &&
                    (eff_cpl > io_privilege_level); // see RQ3

  assign any_fault = flt_ud || flt_priv || flt_lock;
  assign res_lock  = want_lock && !any_fault;

  // decoder sequence and prefix flags
  always_comb begin
    next_state    = state;
    next_pfx_op   = pfx_op;
    next_pfx_addr = pfx_addr;
    next_pfx_lock = pfx_lock;
    case (state)
      osld_pkg::OSLD_ST_SCAN: begin
        if (ins_valid) begin
          // a repeated prefix sets the flag again, never toggles
          if (ins_byte == `OSLD_PFX_OPSIZE) begin
            next_pfx_op = 1'b1; // see RQ15
          end else if (ins_byte == `OSLD_PFX_ADSIZE) begin
            next_pfx_addr = 1'b1; // see RQ15
          end else if (ins_byte == `OSLD_PFX_LOCK) begin
            next_pfx_lock = 1'b1;
          end else begin
            next_state = osld_pkg::OSLD_ST_REPORT;
          end
        end
      end
      osld_pkg::OSLD_ST_REPORT: begin
        next_state    = osld_pkg::OSLD_ST_SCAN;
        next_pfx_op   = 1'b0;
        next_pfx_addr = 1'b0;
        next_pfx_lock = 1'b0;
      end
      default: begin
        next_state = osld_pkg::OSLD_ST_SCAN;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state    <= osld_pkg::OSLD_ST_SCAN;
      pfx_op   <= 1'b0;
      pfx_addr <= 1'b0;
      pfx_lock <= 1'b0;
    end else begin
      state    <= next_state;
      pfx_op   <= next_pfx_op;
      pfx_addr <= next_pfx_addr;
      pfx_lock <= next_pfx_lock;
    end
  end

  // status capture and fault count; a fault in the clear cycle counts as one
  always_comb begin
    next_status = status;
    next_faults = faults;
    if (faults_wr) begin
      next_faults = `OSLD_FAULTS_RESET;
    end
    if (opcode_take) begin
      next_status[`OSLD_ST_OP32]     = res_op32;
      next_status[`OSLD_ST_ADDR32]   = res_addr32;
      next_status[`OSLD_ST_STACK32]  = ss_b; // see RQ12
      next_status[`OSLD_ST_LOCK]     = res_lock;
      next_status[`OSLD_ST_FLT_PRIV] = flt_priv;
      next_status[`OSLD_ST_FLT_UD]   = flt_ud;
      next_status[`OSLD_ST_FLT_LOCK] = flt_lock;
      if (any_fault) begin
        next_faults = faults_wr ? `OSLD_FAULTS_ONE
                                : faults + `OSLD_FAULTS_ONE;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      status <= `OSLD_ST_RESET;
      faults <= `OSLD_FAULTS_RESET;
    end else begin
      status <= next_status;
      faults <= next_faults;
    end
  end

  // result outputs, one pulse per instruction
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dec_valid      <= 1'b0;
      dec_op32       <= 1'b0;
      dec_addr32     <= 1'b0;
      dec_stack32    <= 1'b0;
      dec_lock       <= 1'b0;
      dec_fault_priv <= 1'b0;
      dec_fault_ud   <= 1'b0;
      dec_fault_lock <= 1'b0;
    end else begin
      dec_valid      <= opcode_take;
      dec_op32       <= next_status[`OSLD_ST_OP32];
      dec_addr32     <= next_status[`OSLD_ST_ADDR32];
      dec_stack32    <= next_status[`OSLD_ST_STACK32];
      dec_lock       <= next_status[`OSLD_ST_LOCK];
      dec_fault_priv <= next_status[`OSLD_ST_FLT_PRIV];
      dec_fault_ud   <= next_status[`OSLD_ST_FLT_UD];
      dec_fault_lock <= next_status[`OSLD_ST_FLT_LOCK];
    end
  end

  // bus lock and hold arbitration
  osld_lock_unit u_lock (
    .mclk       (mclk),
    .arst_n     (arst_n),
    .lock_start (opcode_take && res_lock),
    .mem_req    (mem_req),
    .mem_last   (mem_last),
    .mem_gnt    (mem_gnt),
    .bus_lock   (bus_lock),
    .hold_req   (hold_req),
    .hold_ack   (hold_ack)
  );

endmodule

/* File: inc/osld_map.svh */
`ifndef OSLD_MAP_SVH
`define OSLD_MAP_SVH

// register byte addresses on the avalon slave
`define OSLD_ADDR_CTRL      4'h0
`define OSLD_ADDR_STATUS    4'h4
`define OSLD_ADDR_FAULTS    4'h8

// control register fields
`define OSLD_CTRL_MODE_LO   0
`define OSLD_CTRL_MODE_HI   1
`define OSLD_CTRL_CS_D      2
`define OSLD_CTRL_SS_B      3
`define OSLD_CTRL_IO_PRIVILEGE_LEVEL_LO   4
`define OSLD_CTRL_IO_PRIVILEGE_LEVEL_HI   5
`define OSLD_CTRL_CPL_LO    6
`define OSLD_CTRL_CPL_HI    7
`define OSLD_CTRL_RESET     8'h00

// status register fields
`define OSLD_ST_OP32        0
`define OSLD_ST_ADDR32      1
`define OSLD_ST_STACK32     2
`define OSLD_ST_LOCK        3
`define OSLD_ST_FLT_PRIV    4
`define OSLD_ST_FLT_UD      5
`define OSLD_ST_FLT_LOCK    6
`define OSLD_ST_RESET       7'h00

// prefix bytes
`define OSLD_PFX_OPSIZE     8'h66
`define OSLD_PFX_ADSIZE     8'h67
`define OSLD_PFX_LOCK       8'hf0

// privilege level forced while in the compatibility user mode
`define OSLD_COMPAT_CPL     2'h3

`define OSLD_FAULTS_RESET   16'h0000
`define OSLD_FAULTS_ONE     16'h0001

`endif

/* File: inc/osld_pkg.sv */
package osld_pkg;

  // operating mode as programmed in the control register
  typedef enum logic [1:0] {
    OSLD_MODE_REAL   = 2'h0,
    OSLD_MODE_PROT   = 2'h1,
    OSLD_MODE_COMPAT = 2'h2
  } osld_mode_t;

  // instruction class, decoded upstream from the opcode bytes
  typedef enum logic [4:0] {
    OSLD_CLS_OTHER            = 5'h00,
    OSLD_CLS_BIT_TEST_SET     = 5'h01,
    OSLD_CLS_BIT_TEST_RESET   = 5'h02,
    OSLD_CLS_BIT_TEST_COMPL   = 5'h03,
    OSLD_CLS_EXCHANGE         = 5'h04,
    OSLD_CLS_EXCHANGE_ADD     = 5'h05,
    OSLD_CLS_COMPARE_EXCHANGE = 5'h06,
    OSLD_CLS_ALU_ONE          = 5'h07,
    OSLD_CLS_ALU_TWO          = 5'h08,
    OSLD_CLS_LOAD_INT_TABLE   = 5'h09,
    OSLD_CLS_LOAD_GLOBAL_TBL  = 5'h0a,
    OSLD_CLS_LOAD_MACH_STATUS = 5'h0b,
    OSLD_CLS_CTRL_REG_MOVE    = 5'h0c,
    OSLD_CLS_CLEAR_TASK_SW    = 5'h0d,
    OSLD_CLS_HALT             = 5'h0e,
    OSLD_CLS_CACHE_INV        = 5'h0f,
    OSLD_CLS_CACHE_WB_INV     = 5'h10,
    OSLD_CLS_TLB_ENTRY_INV    = 5'h11
  } osld_class_t;

  // decoder states, gray along scan -> report
  typedef enum logic [1:0] {
    OSLD_ST_SCAN   = 2'b00,
    OSLD_ST_REPORT = 2'b01
  } osld_state_t;

endpackage

/* File: hw/osld_lock_unit.sv */
`include "osld_map.svh"

module osld_lock_unit (
  input  wire logic mclk,
  input  wire logic arst_n,
  input  wire logic lock_start,
  input  wire logic mem_req,
  input  wire logic mem_last,
  output logic      mem_gnt,
  output logic      bus_lock,
  input  wire logic hold_req,
  output logic      hold_ack
);

  logic hold_meta;
  logic hold_sync;
  logic locked;
  logic next_locked;
  logic next_hold_ack;

  // two-flop synchroniser for the other master's hold request
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      hold_meta <= 1'b0;
      hold_sync <= 1'b0;
    end else begin
      hold_meta <= hold_req;
      hold_sync <= hold_meta;
    end
  end

  // lock spans the locked instruction up to its last transfer
  always_comb begin
    next_locked = locked;
    if (lock_start) begin
      next_locked = 1'b1; // see RQ6
    end else if (mem_gnt && mem_last) begin
      next_locked = 1'b0;
    end
    // hold granted between parts of any unlocked operand; a granted
    // hold is kept until the other master lets go, so a lock that
    // starts meanwhile never takes the bus back from under it
    next_hold_ack = hold_sync && (hold_ack || !next_locked); // see RQ7
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      locked   <= 1'b0;
      hold_ack <= 1'b0;
    end else begin
      locked   <= next_locked;
      hold_ack <= next_hold_ack;
    end
  end

  // core transfers stall while the other master owns the bus
  assign mem_gnt  = mem_req && !hold_ack; // see RQ7
  assign bus_lock = locked; // see RQ6

endmodule

/* File: dv/osld_chk.sv */
module osld_chk (
  input wire logic                  mclk,
  input wire logic                  arst_n,
  input wire logic                  ins_valid,
  input wire logic                  ins_ready,
  input wire logic [7:0]            ins_byte,
  input wire osld_pkg::osld_class_t ins_class,
  input wire logic                  ins_mem_dest,
  input wire logic                  dec_valid,
  input wire logic                  dec_lock,
  input wire logic                  dec_fault_ud,
  input wire logic                  mem_req,
  input wire logic                  mem_last,
  input wire logic                  mem_gnt,
  input wire logic                  bus_lock,
  input wire logic                  hold_req,
  input wire logic                  hold_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  logic lk_pfx;
  logic next_lk_pfx;
  logic opc;
  logic lk_ok;
  // opcode byte taken, and classes that accept the lock prefix
  assign opc = ins_valid && ins_ready && ins_byte != 8'h66
               && ins_byte != 8'h67 && ins_byte != 8'hf0;
  assign lk_ok = ins_mem_dest && ins_class inside
    {[osld_pkg::OSLD_CLS_BIT_TEST_SET : osld_pkg::OSLD_CLS_ALU_TWO]};
  // remembers a lock prefix until its opcode
  always_comb begin
    next_lk_pfx = lk_pfx;
    if (opc) begin
      next_lk_pfx = 1'b0;
    end else if (ins_valid && ins_ready && ins_byte == 8'hf0) begin
      next_lk_pfx = 1'b1;
    end
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      lk_pfx <= 1'b0;
    end else begin
      lk_pfx <= next_lk_pfx;
    end
  end
  AST_GNT: assert property (mem_gnt == (mem_req && !hold_ack))
    else $error("grant not tied to request and hold");
  AST_HOLD: assert property (
    (hold_req && !bus_lock) [*4] |-> hold_ack)
    else $error("hold not granted in time");
  AST_DEC: assert property (opc |=> dec_valid ##1 !dec_valid)
    else $error("decode pulse wrong");
  AST_READY: assert property (
    dec_valid |-> !ins_ready ##1 ins_ready)
    else $error("byte stream stall wrong");
  AST_UD: assert property (opc && lk_pfx && !lk_ok |=> dec_fault_ud)
    else $error("illegal lock not refused");
  AST_LEGAL: assert property (
    opc && lk_pfx && lk_ok |=> !dec_fault_ud)
    else $error("legal lock refused");
  AST_EXCHANGE_INSTRUCTION: assert property (opc && !lk_pfx && ins_mem_dest
    && ins_class == osld_pkg::OSLD_CLS_EXCHANGE |=> dec_lock)
    else $error("memory exchange not locked");
  AST_KEEP: assert property (
    bus_lock && !(mem_gnt && mem_last) |=> bus_lock)
    else $error("lock dropped early");
  AST_LOCKUP: assert property (dec_valid && dec_lock |-> bus_lock)
    else $error("lock not on bus");
  // main scenarios
  cover property (opc && lk_pfx);
  cover property (hold_ack && mem_req);
  cover property ($fell(bus_lock));
endmodule

bind osld_top osld_chk i_chk (.mclk(mclk), .arst_n(arst_n),
  .ins_valid(ins_valid), .ins_ready(ins_ready), .ins_byte(ins_byte),
  .ins_class(ins_class), .ins_mem_dest(ins_mem_dest),
  .dec_valid(dec_valid), .dec_lock(dec_lock), .dec_fault_ud(dec_fault_ud),
  .mem_req(mem_req), .mem_last(mem_last), .mem_gnt(mem_gnt),
  .bus_lock(bus_lock), .hold_req(hold_req), .hold_ack(hold_ack));

/* File: dv/osld_dma_model.sv */
module osld_dma_model (
  input  wire logic       mclk,
  input  wire logic       go,
  input  wire logic [3:0] hold_cyc,
  input  wire logic       hold_ack,
  output logic            hold_req,
  output int              n_grant
);
  timeunit 1ns;
  timeprecision 1ns;
  // asks for the bus, keeps it hold_cyc cycles once granted
  initial begin
    hold_req = 1'b0;
    n_grant = 0;
    forever begin
      @(posedge mclk);
      if (go) begin
        hold_req <= 1'b1;
      end else if (hold_req && hold_ack) begin
        repeat (hold_cyc) @(posedge mclk);
        hold_req <= 1'b0;
        n_grant <= n_grant + 1;
      end
    end
  end
endmodule

/* File: dv/tb_top.sv */
`include "osld_map.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk, arst_n, avs_read, avs_write, avs_waitrequest, e, go;
  logic [3:0]  avs_address, avs_byteenable, hold_cyc;
  logic [31:0] avs_writedata, avs_readdata, d;
  logic        ins_valid, ins_ready, ins_mem_dest, ins_gate, ins_gate_32;
  logic [7:0]  ins_byte;
  logic        dec_valid, dec_op32, dec_addr32, dec_stack32, dec_lock;
  logic        dec_fault_priv, dec_fault_ud, dec_fault_lock;
  logic        mem_req, mem_last, mem_gnt, bus_lock, hold_req, hold_ack;
  int          n_grant, bad_count, n_checks;
  osld_pkg::osld_class_t ins_class;
  logic [1:0]  im [3] = '{2'h1, 2'h1, 2'h2};
  logic [1:0]  ic [3] = '{2'h3, 2'h0, 2'h0};

  osld_top i_dut (.mclk(mclk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ins_valid(ins_valid), .ins_ready(ins_ready), .ins_byte(ins_byte),
    .ins_class(ins_class), .ins_mem_dest(ins_mem_dest),
    .ins_gate(ins_gate), .ins_gate_32(ins_gate_32),
    .dec_valid(dec_valid), .dec_op32(dec_op32), .dec_addr32(dec_addr32),
    .dec_stack32(dec_stack32), .dec_lock(dec_lock),
    .dec_fault_priv(dec_fault_priv), .dec_fault_ud(dec_fault_ud),
    .dec_fault_lock(dec_fault_lock), .mem_req(mem_req),
    .mem_last(mem_last), .mem_gnt(mem_gnt), .bus_lock(bus_lock),
    .hold_req(hold_req), .hold_ack(hold_ack));
  osld_dma_model i_dma (.mclk(mclk), .go(go), .hold_cyc(hold_cyc),
    .hold_ack(hold_ack), .hold_req(hold_req), .n_grant(n_grant));

  // 20 MHz clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one avalon access, held until waitrequest is seen low
  task av(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    int n;
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    d = avs_readdata;
    if (n == 50) bad_count++;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask

  task wctl(input logic [1:0] m, input logic cd, sb,
            input logic [1:0] io, cp);
    av(1'b1, `OSLD_ADDR_CTRL, {24'h0, cp, io, sb, cd, m});
  endtask

  // one stream byte, held until taken
  task put(input logic [7:0] b, input logic [4:0] c, input logic m);
    int n;
    ins_byte <= b;
    ins_class <= osld_pkg::osld_class_t'(c);
    ins_mem_dest <= m;
    ins_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (ins_ready !== 1'b1 && n < 50);
    if (n == 50) bad_count++;
  endtask

  // prefixes, opcode, then the decode result cycle
  task op(input int no, na, input logic lk, input int c,
          input logic m, g, g32);
    ins_gate <= g;
    ins_gate_32 <= g32;
    repeat (no) put(8'h66, 5'h0, 1'b0);
    repeat (na) put(8'h67, 5'h0, 1'b0);
    if (lk) put(8'hf0, 5'h0, 1'b0);
    put(8'h01, c[4:0], m);
    ins_valid <= 1'b0;
    @(posedge mclk);
    chk(dec_valid, 1);
  endtask

  task mem(input logic last);
    int n;
    mem_req <= 1'b1;
    mem_last <= last;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (mem_gnt !== 1'b1 && n < 60);
    if (n == 60) bad_count++;
    mem_req <= 1'b0;
    @(posedge mclk);
  endtask

  task dma(input logic [3:0] h);
    hold_cyc <= h;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
  endtask

  task conclude();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // watchdog
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    conclude();
  end

  // test sequence
  initial begin
    {arst_n, avs_read, avs_write, ins_valid, ins_mem_dest, go} = 6'h0;
    {ins_gate, ins_gate_32, mem_req, mem_last} = 4'h0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    ins_byte = 8'h0;
    ins_class = osld_pkg::OSLD_CLS_OTHER;
    hold_cyc = 4'h1;
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    av(1'b1, 4'hc, 32'hffffffff);
    av(1'b1, `OSLD_ADDR_STATUS, 32'hffffffff);
    // control write without lane zero must be ignored
    avs_byteenable <= 4'he;
    av(1'b1, `OSLD_ADDR_CTRL, 32'hffffffff);
    avs_byteenable <= 4'hf;
    for (int a = 0; a < 16; a += 4) begin
      av(1'b0, a[3:0], 32'h0);
      chk(d, 0);
    end
    $display("test registers done");
    for (int m = 0; m < 3; m++) for (int cd = 0; cd < 2; cd++)
      for (int p = 0; p < 4; p++) begin
        wctl(m[1:0], cd[0], !cd[0], 2'h0, 2'h0);
        op(p[0] * (1 + cd), p[1] * (1 + cd), 1'b0, 0, 1'b1, 1'b0, 1'b0);
        e = (m == 1) && cd[0];
        chk(dec_op32, e ^ p[0]);
        chk(dec_addr32, e ^ p[1]);
        chk(dec_stack32, !cd[0]);
      end
    for (int g = 0; g < 2; g++) begin
      wctl(2'h1, g[0], 1'b0, 2'h0, 2'h0);
      op(1, 0, 1'b0, 0, 1'b0, 1'b1, g[0]);
      chk(dec_op32, g[0]);
    end
    $display("test sizes done");
    for (int m = 0; m < 3; m += 2) begin
      wctl(m[1:0], 1'b0, 1'b0, 2'h0, 2'h0);
      av(1'b1, `OSLD_ADDR_FAULTS, 32'h0);
      for (int c = 9; c < 18; c++) begin
        op(0, 0, 1'b0, c, 1'b0, 1'b0, 1'b0);
        chk(dec_fault_priv, m == 2);
      end
      av(1'b0, `OSLD_ADDR_FAULTS, 32'h0);
      chk(d, m == 2 ? 32'h9 : 32'h0);
      av(1'b0, `OSLD_ADDR_STATUS, 32'h0);
      chk(d[4], m == 2);
    end
    $display("test privilege done");
    wctl(2'h0, 1'b0, 1'b0, 2'h0, 2'h0);
    for (int c = 0; c < 10; c++) begin
      op(0, 0, 1'b1, c, 1'b1, 1'b0, 1'b0);
      e = c > 0 && c < 9;
      chk(dec_fault_ud, !e);
      chk(bus_lock, e);
      if (e) mem(1'b1);
      chk(bus_lock, 0);
    end
    op(0, 0, 1'b1, 8, 1'b0, 1'b0, 1'b0);
    chk(dec_fault_ud, 1);
    for (int i = 0; i < 3; i++) begin
      wctl(im[i], 1'b0, 1'b0, 2'h0, ic[i]);
      op(0, 0, 1'b1, 8, 1'b1, 1'b0, 1'b0);
      chk(dec_fault_lock, i != 1);
      if (i == 1) mem(1'b1);
    end
    $display("test lock rules done");
    wctl(2'h0, 1'b0, 1'b0, 2'h0, 2'h0);
    op(0, 0, 1'b0, 4, 1'b0, 1'b0, 1'b0);
    chk(dec_lock, 0);
    op(0, 0, 1'b0, 4, 1'b1, 1'b0, 1'b0);
    chk(dec_lock, 1);
    dma(4'h1);
    repeat (8) @(posedge mclk);
    chk(hold_ack, 0);
    mem(1'b0);
    mem(1'b1);
    mem(1'b0);
    dma(4'h5);
    repeat (4) @(posedge mclk);
    chk(hold_ack, 1);
    mem(1'b1);
    chk(n_grant, 2);
    $display("test bus hold done");
    conclude();
  end
endmodule
